// ==== common/uef_pkg.sv ====
// package: register map, field positions and reset values of the endpoint flag / clock control bank
package uef_pkg;
    // ****************************************
    // register map (index, byte address = 4 * index)
    // ****************************************
    localparam logic [7:0]  IDX_FLAGS    = 8'h21;
    localparam logic [7:0]  IDX_CLKCTL   = 8'h22;
    localparam logic [11:0] ADDR_FLAGS   = {2'h0, IDX_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_CLKCTL  = {2'h0, IDX_CLKCTL, 2'h0};

    // ****************************************
    // fields
    // ****************************************
    localparam int          NUM_EP       = 3;
    localparam int          SEL_LSB      = 0;
    localparam int          CLKGATE_BIT  = 3;
    localparam int          SECOND_SUSPEND_POWER_BIT_BIT    = 4;
    localparam int          PLLSEL_BIT   = 5;
    localparam int          XTAL_BIT     = 6;
    localparam logic [2:0]  SEL_EP0      = 3'h0;
    localparam logic [2:0]  SEL_EP1      = 3'h1;
    localparam logic [2:0]  SEL_EP2      = 3'h2;
    localparam logic [2:0]  FLAGS_RST    = 3'h0;
    localparam logic [6:0]  CLKCTL_RST   = 7'h00;
    localparam logic [6:0]  CLKCTL_MASK  = 7'h7F;
endpackage : uef_pkg

// ==== design/uef_bank.sv ====
// design: APB register bank with endpoint request flags and usb clock control
module uef_bank (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  epAccess,
    input  wire logic        usbIntEnable,
    input  wire logic        stackFull,
    output logic             usbIrq,
    output logic             usbClockGate,
    output logic             secondSuspendPower,
    output logic             pllClockSourceSelect,
    output logic             crystalFrequencySelect,
    output logic [2:0]       fifoSelectOneHot,
    output logic [2:0]       fifoSelectField
);
    // ****************************************
    // helpers
    // ****************************************
    // reserved codes enable nothing, so a stray select write cannot
    // steer data toward a fifo that does not exist
    function automatic logic [2:0] sel_decode(input logic [2:0] code);
        logic [2:0] hot;
        hot = 3'h0;
        case (code)
            uef_pkg::SEL_EP0: hot = 3'h1;
            uef_pkg::SEL_EP1: hot = 3'h2;
            uef_pkg::SEL_EP2: hot = 3'h4;
            default:          hot = 3'h0;
        endcase
        return hot;
    endfunction : sel_decode

    // ****************************************
    // bus decode
    // ****************************************
    logic [2:0] epFlags;
    logic [6:0] clkCtl;
    logic [2:0] next_epFlags;
    logic [6:0] next_clkCtl;
    logic [2:0] next_fifoOneHot;
    logic       next_irq;

    wire        accessPhase = psel & penable;
    wire        hitFlags    = paddr == uef_pkg::ADDR_FLAGS;
    wire        hitClk      = paddr == uef_pkg::ADDR_CLKCTL;
    wire        mapped      = hitFlags | hitClk;
    wire        wrLow       = accessPhase & pwrite & pstrb[0];
    wire        wrFlags     = wrLow & hitFlags;
    wire        wrClk       = wrLow & hitClk;
    wire [31:0] rdValue     = hitFlags ? {29'h0, epFlags} :
                              hitClk   ? {25'h0, clkCtl} : 32'h0;

    // firmware may only clear; the engine's set wins in the same cycle
    assign next_epFlags = (wrFlags ? (epFlags & pwdata[2:0]) : epFlags) | epAccess;
    assign next_clkCtl  = wrClk ? (pwdata[6:0] & uef_pkg::CLKCTL_MASK) : clkCtl;
    assign next_irq     = (|next_epFlags) & usbIntEnable & ~stackFull;

    // reserved codes decode to no endpoint at all
    wire [2:0] selCode = next_clkCtl[uef_pkg::SEL_LSB +: 3];
    assign next_fifoOneHot = sel_decode(selCode);

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            epFlags <= uef_pkg::FLAGS_RST;
            clkCtl  <= uef_pkg::CLKCTL_RST;
        end else begin
            epFlags <= next_epFlags;
            clkCtl  <= next_clkCtl;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            usbIrq                 <= 1'b0;
            usbClockGate           <= 1'b0;
            secondSuspendPower     <= 1'b0;
            pllClockSourceSelect   <= 1'b0;
            crystalFrequencySelect <= 1'b0;
            fifoSelectOneHot       <= 3'h1;
            fifoSelectField        <= 3'h0;
        end else begin
            usbIrq                 <= next_irq;
            usbClockGate           <= next_clkCtl[uef_pkg::CLKGATE_BIT];
            secondSuspendPower     <= next_clkCtl[uef_pkg::SECOND_SUSPEND_POWER_BIT_BIT];
            pllClockSourceSelect   <= next_clkCtl[uef_pkg::PLLSEL_BIT];
            crystalFrequencySelect <= next_clkCtl[uef_pkg::XTAL_BIT];
            fifoSelectOneHot       <= next_fifoOneHot;
            fifoSelectField        <= selCode;
        end
    end

    // answer in the first access cycle; one wait-free cycle per transfer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdValue : 32'h0;
        end
    end

    // ****************************************
    // checks: endpoint flags
    // ****************************************
    // each strobed endpoint shows its flag one edge later
    chk_flag_set: assert property (@(posedge mclk) disable iff (rst)
        epAccess[0] |=> epFlags[0])
        else $error("endpoint flag not set on access");

    chk_flag_one: assert property (@(posedge mclk) disable iff (rst)
        epAccess[1] |=> epFlags[1])
        else $error("endpoint one flag not set on access");

    chk_flag_two: assert property (@(posedge mclk) disable iff (rst)
        epAccess[2] |=> epFlags[2])
        else $error("endpoint two flag not set on access");

    // a clear that meets a set in the same cycle must lose
    chk_set_wins: assert property (@(posedge mclk) disable iff (rst)
        (wrFlags & ~pwdata[1] & epAccess[1]) |=> epFlags[1])
        else $error("firmware clear beat engine set");

    // a clear with no set in its way does take effect
    chk_clear_works: assert property (@(posedge mclk) disable iff (rst)
        (wrFlags & ~pwdata[0] & ~epAccess[0]) |=> ~epFlags[0])
        else $error("firmware clear of endpoint flag ignored");

    // writing a one never raises a flag on its own
    chk_write_one: assert property (@(posedge mclk) disable iff (rst)
        (wrFlags & pwdata[2] & ~epFlags[2] & ~epAccess[2]) |=> ~epFlags[2])
        else $error("firmware write raised an endpoint flag");

    // only firmware may drop a pending flag
    chk_flag_hold: assert property (@(posedge mclk) disable iff (rst)
        (epFlags[2] & ~wrFlags) |=> epFlags[2])
        else $error("flag dropped without firmware clear");

    chk_flag_quiet: assert property (@(posedge mclk) disable iff (rst)
        ((~|epAccess) & ~wrFlags) |=> $stable(epFlags))
        else $error("flags changed with no access and no write");

    // unused high bits of the flag register always read zero
    chk_upper_zero: assert property (@(posedge mclk) disable iff (rst)
        (pready & ~pwrite & hitFlags) |-> prdata[31:3] == 29'h0)
        else $error("unused flag bits read nonzero");

    // ****************************************
    // checks: interrupt request
    // ****************************************
    // registered request, judged on the flags as they will stand
    chk_irq_gate: assert property (@(posedge mclk) disable iff (rst)
        usbIrq |-> $past(usbIntEnable) & ~$past(stackFull))
        else $error("interrupt raised while disabled or stack full");

    chk_irq_raise: assert property (@(posedge mclk) disable iff (rst)
        ((|epFlags) & usbIntEnable & ~stackFull & ~wrFlags) |=> usbIrq)
        else $error("pending flag did not request interrupt");

    // a full stack or a disabled interrupt drops the request at the next edge
    chk_irq_masked: assert property (@(posedge mclk) disable iff (rst)
        (~usbIntEnable | stackFull) |=> ~usbIrq)
        else $error("interrupt requested while it cannot be taken");

    // no request without a pending endpoint behind it
    chk_irq_cause: assert property (@(posedge mclk) disable iff (rst)
        usbIrq |-> (|epFlags))
        else $error("interrupt requested with no flag pending");

    // ****************************************
    // checks: clock control
    // ****************************************
    // gate output follows a write and holds until the next one
    chk_gate_follow: assert property (@(posedge mclk) disable iff (rst)
        (wrClk & pwdata[3]) |=> usbClockGate ##1 (usbClockGate || wrClk))
        else $error("usb clock gate did not follow write");

    chk_gate_stop: assert property (@(posedge mclk) disable iff (rst)
        (wrClk & ~pwdata[3]) |=> ~usbClockGate)
        else $error("usb clock gate did not stop on write");

    // the gate pin and the stored bit must never disagree
    chk_gate_mirror: assert property (@(posedge mclk) disable iff (rst)
        usbClockGate == clkCtl[uef_pkg::CLKGATE_BIT])
        else $error("usb clock gate differs from stored bit");

    chk_pll_sel: assert property (@(posedge mclk) disable iff (rst)
        wrClk |=> pllClockSourceSelect == $past(pwdata[5]))
        else $error("clock source select mismatch");

    chk_pll_mirror: assert property (@(posedge mclk) disable iff (rst)
        pllClockSourceSelect == clkCtl[uef_pkg::PLLSEL_BIT])
        else $error("clock source select differs from stored bit");

    // power and crystal bits are plain stored levels; firmware owns their meaning
    chk_susp_mirror: assert property (@(posedge mclk) disable iff (rst)
        secondSuspendPower == clkCtl[uef_pkg::SECOND_SUSPEND_POWER_BIT_BIT])
        else $error("suspend power bit differs from stored bit");

    chk_xtal_mirror: assert property (@(posedge mclk) disable iff (rst)
        crystalFrequencySelect == clkCtl[uef_pkg::XTAL_BIT])
        else $error("crystal select differs from stored bit");

    // bit 7 is not stored and reads zero
    chk_bit7_zero: assert property (@(posedge mclk) disable iff (rst)
        (pready & ~pwrite & hitClk) |-> prdata[31:7] == 25'h0)
        else $error("unstored control bits read nonzero");

    // a write without lane 0 strobed leaves the byte untouched
    chk_strb_ignore: assert property (@(posedge mclk) disable iff (rst)
        (accessPhase & pwrite & ~pstrb[0] & hitClk) |=> $stable(clkCtl))
        else $error("unstrobed write changed clock control");

    chk_clk_hold: assert property (@(posedge mclk) disable iff (rst)
        ~wrClk |=> $stable(clkCtl))
        else $error("clock control changed without a write");

    // ****************************************
    // checks: fifo select
    // ****************************************
    chk_sel_ep0: assert property (@(posedge mclk) disable iff (rst)
        (fifoSelectField == uef_pkg::SEL_EP0) |-> fifoSelectOneHot == 3'h1)
        else $error("code zero did not select endpoint zero fifo");

    chk_sel_ep1: assert property (@(posedge mclk) disable iff (rst)
        (fifoSelectField == uef_pkg::SEL_EP1) |-> fifoSelectOneHot == 3'h2)
        else $error("code one did not select endpoint one fifo");

    chk_sel_ep2: assert property (@(posedge mclk) disable iff (rst)
        (fifoSelectField == uef_pkg::SEL_EP2) |-> fifoSelectOneHot == 3'h4)
        else $error("code two did not select endpoint two fifo");

    // at most one fifo is ever steered, none for reserved codes
    chk_sel_onehot: assert property (@(posedge mclk) disable iff (rst)
        $onehot0(fifoSelectOneHot))
        else $error("more than one fifo selected");

    chk_reserved_sel: assert property (@(posedge mclk) disable iff (rst)
        (fifoSelectField > 3'h2) |-> fifoSelectOneHot == 3'h0)
        else $error("reserved select enabled a fifo");

    // the field output always shows the stored code
    chk_sel_mirror: assert property (@(posedge mclk) disable iff (rst)
        fifoSelectField == clkCtl[uef_pkg::SEL_LSB +: 3])
        else $error("select field differs from stored code");

    // ****************************************
    // checks: reset
    // ****************************************
    // no disable here: these look at the first edge after release
    chk_reset_zero: assert property (@(posedge mclk)
        $fell(rst) |-> clkCtl == 7'h00 && fifoSelectOneHot == 3'h1)
        else $error("bank not zero after reset");

    chk_reset_flags: assert property (@(posedge mclk)
        $fell(rst) |-> epFlags == 3'h0 && !usbIrq && !usbClockGate)
        else $error("flags or request not clear after reset");

    // ****************************************
    // checks: bus handshake
    // ****************************************
    // zero wait states: ready is registered from the setup cycle
    chk_ready_setup: assert property (@(posedge mclk) disable iff (rst)
        (psel & ~penable) |=> pready)
        else $error("no ready in first access cycle");

    chk_ready_pulse: assert property (@(posedge mclk) disable iff (rst)
        pready |=> ~pready)
        else $error("ready stood longer than one cycle");

    chk_err_unmapped: assert property (@(posedge mclk) disable iff (rst)
        (psel & ~penable & ~mapped) |=> pslverr)
        else $error("unmapped access not flagged");

    chk_err_mapped: assert property (@(posedge mclk) disable iff (rst)
        (psel & ~penable & mapped) |=> ~pslverr)
        else $error("mapped access flagged as error");

    // read data is forced low outside the answer cycle
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
        ~pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");

    // ****************************************
    // main scenarios
    // ****************************************
    cov_ep_irq:    cover property (@(posedge mclk) disable iff (rst) epAccess[2] ##1 usbIrq);
    cov_clear:     cover property (@(posedge mclk) disable iff (rst) epFlags[0] & wrFlags ##1 ~epFlags[0]);
    cov_reserved:  cover property (@(posedge mclk) disable iff (rst) fifoSelectField == 3'h7);
    cov_set_wins:  cover property (@(posedge mclk) disable iff (rst) wrFlags & ~pwdata[1] & epAccess[1]);
    cov_bus_error: cover property (@(posedge mclk) disable iff (rst) pready & pslverr);
endmodule : uef_bank

// ==== bench/uef_engine_model.sv ====
// engine model: endpoint access strobes toward the flag register
module uef_engine_model (
    input  wire logic       mclk,
    output logic      [2:0] epAccess
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // access strobes
    // ****************************************
    initial epAccess = 3'h0;
    // one-cycle strobe; a held level would keep re-setting flags firmware clears
    task automatic pulse(input logic [2:0] ep);
        epAccess <= ep;
        @(posedge mclk);
        epAccess <= 3'h0;
    endtask : pulse
endmodule : uef_engine_model

// ==== bench/tb_top.sv ====
// testbench: register bank driven over APB, engine model on the endpoint side
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, usbIntEnable, stackFull, usbIrq, slv;
    logic        usbClockGate, secondSuspendPower, pllClockSourceSelect, crystalFrequencySelect;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [2:0]  epAccess, fifoSelectOneHot, fifoSelectField;
    int          err_total, samples_checked;
    uef_bank u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .epAccess, .usbIntEnable, .stackFull, .usbIrq, .usbClockGate, .secondSuspendPower,
        .pllClockSourceSelect, .crystalFrequencySelect, .fifoSelectOneHot, .fifoSelectField);
    uef_engine_model u_eng (.mclk, .epAccess);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, expv);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // entered just after an edge; waits a bounded time for pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        if (n >= 16) tally_and_finish();
        rd = prdata;
        slv = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge mclk);
    endtask : xfer
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, stackFull} = '0;
        {rst, usbIntEnable, pstrb} = {1'b1, 1'b1, 4'hF};
        err_total = 0;
        samples_checked = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({usbClockGate, secondSuspendPower, pllClockSourceSelect, crystalFrequencySelect,
             fifoSelectOneHot}, 7'h01);
        xfer(1'b0, uef_pkg::ADDR_CLKCTL, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'hF8 | 32'(i));
            xfer(1'b0, uef_pkg::ADDR_CLKCTL, 32'h0);
            chk(rd, 32'h78 | 32'(i));
            chk(fifoSelectOneHot, (i < 3) ? 32'(1 << i) : 32'h0);
            chk(fifoSelectField, 32'(i));
        end
        chk(slv, 1'b0);
        chk({usbClockGate, secondSuspendPower, pllClockSourceSelect, crystalFrequencySelect}, 32'hF);
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h20);
        chk({usbClockGate, secondSuspendPower, pllClockSourceSelect, crystalFrequencySelect}, 32'h2);
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h48);
        chk({usbClockGate, crystalFrequencySelect}, 32'h3);
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h40);
        chk(usbClockGate, 1'b0);
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h50);
        chk(secondSuspendPower, 1'b1);
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h48);
        chk({usbClockGate, secondSuspendPower}, 32'h2);
        pstrb <= 4'hE;
        xfer(1'b1, uef_pkg::ADDR_CLKCTL, 32'h07);
        pstrb <= 4'hF;
        xfer(1'b0, uef_pkg::ADDR_CLKCTL, 32'h0);
        chk(rd, 32'h48);
        $display("clock control test done");
        u_eng.pulse(3'h7);
        xfer(1'b0, uef_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h7);
        chk(usbIrq, 1'b1);
        stackFull <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(usbIrq, 1'b0);
        {stackFull, usbIntEnable} <= 2'b00;
        repeat (2) @(posedge mclk);
        chk(usbIrq, 1'b0);
        usbIntEnable <= 1'b1;
        xfer(1'b1, uef_pkg::ADDR_FLAGS, 32'hFA);
        xfer(1'b0, uef_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h2);
        xfer(1'b0, 12'h000, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        xfer(1'b1, uef_pkg::ADDR_FLAGS, 32'h4);
        xfer(1'b0, uef_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        fork
            xfer(1'b1, uef_pkg::ADDR_FLAGS, 32'h0);
            begin
                @(posedge mclk);
                u_eng.pulse(3'h2);
            end
        join
        xfer(1'b0, uef_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h2);
        chk(usbIrq, 1'b1);
        $display("flag test done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({usbIrq, usbClockGate, secondSuspendPower, pllClockSourceSelect, crystalFrequencySelect,
             fifoSelectOneHot}, 32'h01);
        xfer(1'b0, uef_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        tally_and_finish();
    end
endmodule : tb_top
